//--- bench/asg_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// outside world of one port: no pulls on the pins
// ****
module asg_pin_model
    import asg_pkg::*;
(
    input wire asg_pin_drive_type drive, // block drive
    input wire logic [DATA_W-1:0] ext, // level forced from outside
    output logic [DATA_W-1:0] pin // resolved pin level
);
    // driven pins follow drive.out, released pins show the outside level
    assign pin = (drive.oe & drive.out) | (~drive.oe & ext);
endmodule : asg_pin_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bench for the three shared analog ports
// ****
module tb
    import asg_pkg::*;
;
    logic clk_sys = 1'b0; // system clock
    logic nrst = 1'b0; // reset, low
    logic [ADDR_W-1:0] a = '0; // register address
    logic [DATA_W-1:0] wd = '0; // write data
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic [DATA_W-1:0] rdat; // read data
    asg_pin_drive_type dv [3]; // drives of f, g, h
    logic [DATA_W-1:0] ext [3] = '{8'hff, 8'hff, 8'hff}; // outside levels
    logic [DATA_W-1:0] pin [3]; // resolved pins
    logic [NUM_CH-1:0] an; // analog channels
    logic [1:0] cks; // converter clock field
    logic fmt, cap, sdl, scl; // format and peripheral levels
    logic pe = 0, po = 0, se = 0, sd = 0, sdo = 0, sc = 0, sco = 0;
    int error_cnt = 0; // mismatches
    int samples_checked = 0; // comparisons
    always #10 clk_sys = ~clk_sys;
    for (genvar i = 0; i < 3; i++) begin : g_pin
        asg_pin_model pm_u (.drive(dv[i]), .ext(ext[i]), .pin(pin[i]));
    end
    asg_gpio dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(a),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .pf_pin_i(pin[0]), .pf_drive(dv[0]), .pg_pin_i(pin[1]),
        .pg_drive(dv[1]), .ph_pin_i(pin[2]), .ph_drive(dv[2]),
        .analog_sel(an), .adc_clk_sel(cks), .adc_fmt(fmt), .g_pwm_en(pe),
        .g_pwm_out(po), .g_ser_en(se), .g_ser_dat_out(sd),
        .g_ser_dat_oe(sdo), .g_ser_clk_out(sc), .g_ser_clk_oe(sco),
        .g_cap_level(cap), .g_ser_dat_level(sdl), .g_ser_clk_level(scl));
    // ****
    // checks, bus cycles, expectations
    // ****
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic wrt(logic [11:0] ad, logic [7:0] d);
        @(posedge clk_sys);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wrt
    // read data stand only in the cycle after the strobe edge
    task automatic rdr(logic [11:0] ad, logic [7:0] e);
        @(posedge clk_sys);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        chk("reg_rdata", 16'(rdat), 16'(e));
    endtask : rdr
    // pins need two sync stages and a level register
    task automatic settle;
        repeat (5) @(posedge clk_sys);
    endtask : settle
    function automatic logic [11:0] dir_ad(int p);
        return p == 0 ? 12'h510 : p == 1 ? 12'h512 : 12'h810;
    endfunction : dir_ad
    function automatic int chan(int p, int b); // -1: never analog
        if (p == 0) return F_CH_BASE + b;
        if (p == 1) return b <= G_CH_TOP ? G_CH_TOP - b : -1;
        return b >= H_AN_LSB ? H_CH_BASE + b - H_AN_LSB : -1;
    endfunction : chan
    function automatic logic an_ch(int k, int c);
        return k >= 0 && c < 14 && k + c < 16;
    endfunction : an_ch
    function automatic logic [7:0] dmask(int p, int c); // digital bits
        logic [7:0] m;
        for (int b = 0; b < 8; b++) m[b] = !an_ch(chan(p, b), c);
        return m;
    endfunction : dmask
    // ****
    // main sequence
    // ****
    initial begin
        logic [7:0] d, l;
        logic [15:0] ev;
        void'($urandom(32'h066a));
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            rdr(dir_ad(p), 8'hff);
            rdr(dir_ad(p) + 12'h001, dmask(p, 0) & ext[p]);
        end
        chk("analog_sel", an, 16'hffff);
        rdr(12'h515, 8'h00);
        rdr(12'h514, 8'h00);
        rdr(12'h410, 8'h00);
        $display("test reset done");
        // every config code, reserved bit always set in the write
        for (int c = 0; c < 16; c++) begin
            for (int k = 0; k < 16; k++) ev[k] = an_ch(k, c);
            @(posedge clk_sys);
            for (int p = 0; p < 3; p++) ext[p] <= 8'($urandom);
            wrt(12'h515, 8'(c) | 8'hf0);
            settle();
            rdr(12'h515, (8'(c) | 8'hf0) & 8'hef);
            chk("analog_sel", an, ev);
            chk("conv_fields", {cks, fmt}, 3'b111);
            for (int p = 0; p < 3; p++)
                rdr(dir_ad(p) + 12'h001, dmask(p, c) & ext[p]);
        end
        $display("test config done");
        for (int n = 0; n < 24; n++) begin
            d = n < 3 ? 8'h00 : n < 6 ? 8'hff : 8'($urandom);
            l = 8'($urandom);
            @(posedge clk_sys);
            ext[n % 3] <= 8'($urandom);
            wrt(dir_ad(n % 3), d);
            wrt(dir_ad(n % 3) + 1, l);
            settle();
            chk("oe", dv[n % 3].oe, 8'(~d));
            chk("out", dv[n % 3].out & ~d, l & ~d);
            rdr(dir_ad(n % 3) + 12'h001, (~d & l) | (d & ext[n % 3]));
        end
        $display("test direction done");
        wrt(12'h515, 8'h00);
        wrt(12'h510, 8'h00);
        settle();
        chk("analog_oe", dv[0].oe, 16'h0000);
        wrt(12'h515, 8'h0e);
        wrt(12'h512, 8'hff);
        for (int n = 0; n < 6; n++) begin
            @(posedge clk_sys);
            {po, sd, sdo, sc, sco} <= 5'($urandom);
            pe <= 1'b1;
            se <= 1'b1;
            ext[1] <= 8'($urandom);
            settle();
            chk("g_oe", dv[1].oe[7:5], {sco, sdo, 1'b1});
            chk("g_out", dv[1].out[7:5] & {sco, sdo, 1'b1},
                {sc & sco, sd & sdo, po});
            chk("cap", cap, ext[1][4]);
            chk("ser", {scl, sdl}, {pin[1][7], pin[1][6]});
        end
        $display("test peripheral done");
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        rdr(12'h510, 8'hff);
        rdr(12'h512, 8'hff);
        $display("test second reset done");
        end_sim();
    end
    // watchdog well beyond the few hundred cycles of the run
    initial begin
        #(20 * 20000);
        error_cnt++;
        end_sim();
    end
endmodule : tb
`default_nettype wire

//--- hw/asg_gpio.sv
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module asg_gpio
    import asg_pkg::*;
(
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic nrst, // async reset, low
    input wire logic [ADDR_W-1:0] reg_addr, // {bank, offset}
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, next cycle
    input wire logic [DATA_W-1:0] pf_pin_i, // port f pin levels
    output asg_pin_drive_type pf_drive, // port f drive
    input wire logic [DATA_W-1:0] pg_pin_i, // port g pin levels
    output asg_pin_drive_type pg_drive, // port g drive
    input wire logic [DATA_W-1:0] ph_pin_i, // port h pin levels
    output asg_pin_drive_type ph_drive, // port h drive
    output logic [NUM_CH-1:0] analog_sel, // channels set analog
    output logic [1:0] adc_clk_sel, // converter clock field
    output logic adc_fmt, // converter result format
    input wire logic g_pwm_en, // pwm owns its pin
    input wire logic g_pwm_out, // pwm level
    input wire logic g_ser_en, // serial unit owns its pins
    input wire logic g_ser_dat_out, // serial data level
    input wire logic g_ser_dat_oe, // serial data enable
    input wire logic g_ser_clk_out, // serial clock level
    input wire logic g_ser_clk_oe, // serial clock enable
    output logic g_cap_level, // capture pin level
    output logic g_ser_dat_level, // serial data pin level
    output logic g_ser_clk_level // serial clock pin level
);
    // ************************************************************
    // declarations
    // ************************************************************
    logic [BANK_W-1:0] bank; // addressed bank
    logic [OFS_W-1:0] ofs; // addressed offset
    logic in_fg; // bank of ports f, g
    logic in_h; // bank of port h
    logic f_dir_wr; // port f direction write
    logic f_dat_wr; // port f latch write
    logic g_dir_wr; // port g direction write
    logic g_dat_wr; // port g latch write
    logic h_dir_wr; // port h direction write
    logic h_dat_wr; // port h latch write
    logic conv_wr; // converter control write
    logic [DATA_W-1:0] conv_q; // converter control
    logic [DATA_W-1:0] conv_d; // its next value
    logic [DATA_W-1:0] rdata_d; // next read data
    logic [CFG_W-1:0] cfg; // pin configuration code
    logic [DATA_W-1:0] pf_analog; // port f analog pins
    logic [DATA_W-1:0] pg_analog; // port g analog pins
    logic [DATA_W-1:0] ph_analog; // port h analog pins
    logic [DATA_W-1:0] pg_per_en; // port g peripheral owner
    logic [DATA_W-1:0] pg_per_out; // port g peripheral level
    logic [DATA_W-1:0] pg_per_oe; // port g peripheral enable
    logic [DATA_W-1:0] pf_dir; // port f direction
    logic [DATA_W-1:0] pg_dir; // port g direction
    logic [DATA_W-1:0] ph_dir; // port h direction
    logic [DATA_W-1:0] pf_latch; // port f latch
    logic [DATA_W-1:0] pg_latch; // port g latch
    logic [DATA_W-1:0] ph_latch; // port h latch
    logic [DATA_W-1:0] pf_level; // port f visible level
    logic [DATA_W-1:0] pg_level; // port g visible level
    logic [DATA_W-1:0] ph_level; // port h visible level
    logic cfg_seen_q; // helper: converter written
    logic dir_seen_q; // helper: an f or g direction written

    // ************************************************************
    // address decode
    // ************************************************************
    // the bank is part of the address, so software that forgets
    // to select the right bank simply misses the register
    always_comb begin
        bank = reg_addr[ADDR_W-1 -: BANK_W];
        ofs = reg_addr[OFS_W-1:0];
        in_fg = (bank == BANK_FG);
        in_h = (bank == BANK_H);
        f_dir_wr = reg_wr && in_fg && (ofs == OFS_F_DIR);
        f_dat_wr = reg_wr && in_fg && (ofs == OFS_F_DATA);
        g_dir_wr = reg_wr && in_fg && (ofs == OFS_G_DIR);
        g_dat_wr = reg_wr && in_fg && (ofs == OFS_G_DATA);
        conv_wr = reg_wr && in_fg && (ofs == OFS_CONV);
        h_dir_wr = reg_wr && in_h && (ofs == OFS_H_DIR);
        h_dat_wr = reg_wr && in_h && (ofs == OFS_H_DATA);
    end

    // ************************************************************
    // converter control register
    // ************************************************************
    // the unimplemented bit is masked so it always reads zero
    always_comb begin
        conv_d = conv_q;
        if (conv_wr) begin
            conv_d = reg_wdata & CONV_RW_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            conv_q <= CONV_RST;
        end else begin
            conv_q <= conv_d;
        end
    end

    // ************************************************************
    // analog channel selection
    // ************************************************************
    // code c leaves channels below 16 - c analog; the two top
    // codes free every pin. reset code zero is all analog.
    always_comb begin
        cfg = conv_q[CFG_LSB +: CFG_W];
        adc_clk_sel = conv_q[CLK_LSB +: 2];
        adc_fmt = conv_q[FMT_BIT];
        for (int k = 0; k < NUM_CH; k++) begin
            analog_sel[k] = (cfg < CFG_DIGITAL_MIN) &&
                ((k + int'(cfg)) < NUM_CH);
        end
    end

    // ************************************************************
    // channel to pin mapping
    // ************************************************************
    always_comb begin
        pg_analog = '0;
        ph_analog = '0;
        for (int i = 0; i < DATA_W; i++) begin
            pf_analog[i] = analog_sel[F_CH_BASE + i];
        end
        // low nibble of g runs channels in reverse; the top two
        // also carry the converter references while analog
        for (int i = 0; i <= G_CH_TOP; i++) begin
            pg_analog[i] = analog_sel[G_CH_TOP - i];
        end
        for (int i = H_AN_LSB; i < DATA_W; i++) begin
            ph_analog[i] = analog_sel[H_CH_BASE + i - H_AN_LSB];
        end
    end

    // ************************************************************
    // port g peripheral sharing
    // ************************************************************
    // capture is input only: the pin keeps its port function
    always_comb begin
        pg_per_en = '0;
        pg_per_out = '0;
        pg_per_oe = '0;
        pg_per_en[G_PWM_BIT] = g_pwm_en;
        pg_per_out[G_PWM_BIT] = g_pwm_out;
        pg_per_oe[G_PWM_BIT] = 1'b1;
        pg_per_en[G_DAT_BIT] = g_ser_en;
        pg_per_out[G_DAT_BIT] = g_ser_dat_out;
        pg_per_oe[G_DAT_BIT] = g_ser_dat_oe;
        pg_per_en[G_CLK_BIT] = g_ser_en;
        pg_per_out[G_CLK_BIT] = g_ser_clk_out;
        pg_per_oe[G_CLK_BIT] = g_ser_clk_oe;
        g_cap_level = pg_level[G_CAP_BIT];
        g_ser_dat_level = pg_level[G_DAT_BIT];
        g_ser_clk_level = pg_level[G_CLK_BIT];
    end

    // ************************************************************
    // the three ports
    // ************************************************************
    asg_port_slice #(.WIDTH(DATA_W)) u_port_f (
        .clk_sys(clk_sys), .nrst(nrst), .dir_wr(f_dir_wr),
        .data_wr(f_dat_wr), .wdata(reg_wdata), .analog(pf_analog),
        .per_en('0), .per_out('0), .per_oe('0), .pin_i(pf_pin_i),
        .dir_q(pf_dir), .latch_q(pf_latch), .drive_q(pf_drive),
        .level_q(pf_level)
    );

    asg_port_slice #(.WIDTH(DATA_W)) u_port_g (
        .clk_sys(clk_sys), .nrst(nrst), .dir_wr(g_dir_wr),
        .data_wr(g_dat_wr), .wdata(reg_wdata), .analog(pg_analog),
        .per_en(pg_per_en), .per_out(pg_per_out), .per_oe(pg_per_oe),
        .pin_i(pg_pin_i), .dir_q(pg_dir), .latch_q(pg_latch),
        .drive_q(pg_drive), .level_q(pg_level)
    );

    asg_port_slice #(.WIDTH(DATA_W)) u_port_h (
        .clk_sys(clk_sys), .nrst(nrst), .dir_wr(h_dir_wr),
        .data_wr(h_dat_wr), .wdata(reg_wdata), .analog(ph_analog),
        .per_en('0), .per_out('0), .per_oe('0), .pin_i(ph_pin_i),
        .dir_q(ph_dir), .latch_q(ph_latch), .drive_q(ph_drive),
        .level_q(ph_level)
    );

    // ************************************************************
    // read path
    // ************************************************************
    // data offsets return pin levels, not the latch; unmapped
    // addresses and idle cycles return zero. analog bits are
    // masked again: the level register lags a config write
    always_comb begin
        rdata_d = '0;
        if (reg_rd && in_fg) begin
            case (ofs)
                OFS_F_DIR: rdata_d = pf_dir;
                OFS_F_DATA: rdata_d = pf_level & ~pf_analog;
                OFS_G_DIR: rdata_d = pg_dir;
                OFS_G_DATA: rdata_d = pg_level & ~pg_analog;
                OFS_CONV: rdata_d = conv_q;
                default: rdata_d = '0;
            endcase
        end else if (reg_rd && in_h) begin
            case (ofs)
                OFS_H_DIR: rdata_d = ph_dir;
                OFS_H_DATA: rdata_d = ph_level & ~ph_analog;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // helpers: remember whether software touched config/direction
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_seen_q <= 1'b0;
            dir_seen_q <= 1'b0;
        end else begin
            cfg_seen_q <= cfg_seen_q | conv_wr;
            dir_seen_q <= dir_seen_q | f_dir_wr | g_dir_wr;
        end
    end

    property p_dir_one_no_drive;
        @(posedge clk_sys) disable iff (!nrst)
        pf_dir[0] |=> !pf_drive.oe[0];
    endproperty
    a_dir_one_no_drive: assert property (p_dir_one_no_drive)
        else $error("input pin still driven");
    property p_dir_zero_drives;
        @(posedge clk_sys) disable iff (!nrst)
        (!pf_dir[1] && !pf_analog[1]) |=>
            (pf_drive.oe[1] && pf_drive.out[1] == $past(pf_latch[1]));
    endproperty
    a_dir_zero_drives: assert property (p_dir_zero_drives)
        else $error("output pin not driven from latch");
    property p_read_gives_pins;
        @(posedge clk_sys) disable iff (!nrst)
        (reg_rd && in_fg && ofs == OFS_F_DATA) |=>
            (reg_rdata == ($past(pf_level) & ~$past(pf_analog)));
    endproperty
    a_read_gives_pins: assert property (p_read_gives_pins)
        else $error("data read does not show pin level");
    property p_write_sets_latch;
        @(posedge clk_sys) disable iff (!nrst)
        g_dat_wr |=> (pg_latch == $past(reg_wdata)) && $stable(pg_dir);
    endproperty
    a_write_sets_latch: assert property (p_write_sets_latch)
        else $error("data write did not reach latch only");
    property p_reset_analog;
        @(posedge clk_sys) disable iff (!nrst)
        !cfg_seen_q |-> (pf_analog == 8'hff && pg_analog == 8'h0f &&
            ph_analog == 8'hf0);
    endproperty
    a_reset_analog: assert property (p_reset_analog)
        else $error("shared pins not analog after reset");
    property p_reset_dir;
        @(posedge clk_sys) disable iff (!nrst)
        !dir_seen_q |-> (pf_dir == DIR_RST && pg_dir == DIR_RST);
    endproperty
    a_reset_dir: assert property (p_reset_dir)
        else $error("direction not all inputs after reset");
    property p_channel_map;
        @(posedge clk_sys) disable iff (!nrst)
        (pf_analog == analog_sel[11:4]) && (ph_analog[7:4] ==
            analog_sel[15:12]) && (pg_analog[3:0] == {analog_sel[0],
            analog_sel[1], analog_sel[2], analog_sel[3]});
    endproperty
    a_channel_map: assert property (p_channel_map)
        else $error("pin to channel map broken");
    property p_cfg_digital;
        @(posedge clk_sys) disable iff (!nrst)
        (conv_wr && reg_wdata[3:0] == 4'he) |=> (analog_sel == '0) ##1
            (pf_drive.oe == ~$past(pf_dir));
    endproperty
    a_cfg_digital: assert property (p_cfg_digital)
        else $error("digital code leaves analog pins");
    property p_analog_reads_zero;
        @(posedge clk_sys) disable iff (!nrst)
        (reg_rd && in_fg && ofs == OFS_F_DATA && pf_analog[2]) |=>
            !reg_rdata[2];
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("analog pin reads one");
    property p_pwm_owns_pin;
        @(posedge clk_sys) disable iff (!nrst)
        g_pwm_en |=> (pg_drive.oe[5] && pg_drive.out[5] ==
            $past(g_pwm_out));
    endproperty
    a_pwm_owns_pin: assert property (p_pwm_owns_pin)
        else $error("pwm does not drive its pin");
    property p_ser_owns_pins;
        @(posedge clk_sys) disable iff (!nrst)
        g_ser_en |=> (pg_drive.oe[7] == $past(g_ser_clk_oe)) &&
            (pg_drive.out[6] == $past(g_ser_dat_out));
    endproperty
    a_ser_owns_pins: assert property (p_ser_owns_pins)
        else $error("serial unit does not own its pins");
endmodule : asg_gpio
`default_nettype wire

//--- hw/asg_pkg.sv
// ****************************************************************
// constants shared by the port block and its per-port slice
// ****************************************************************
package asg_pkg;
    // bus geometry: bank number in the top nibble, offset below
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFS_W = 8;
    // banks holding the port registers
    localparam logic [BANK_W-1:0] BANK_FG = 4'h5;
    localparam logic [BANK_W-1:0] BANK_H = 4'h8;
    // register offsets inside a bank
    localparam logic [OFS_W-1:0] OFS_F_DIR = 8'h10;
    localparam logic [OFS_W-1:0] OFS_F_DATA = 8'h11;
    localparam logic [OFS_W-1:0] OFS_G_DIR = 8'h12;
    localparam logic [OFS_W-1:0] OFS_G_DATA = 8'h13;
    localparam logic [OFS_W-1:0] OFS_CONV = 8'h15;
    localparam logic [OFS_W-1:0] OFS_H_DIR = 8'h10;
    localparam logic [OFS_W-1:0] OFS_H_DATA = 8'h11;
    // reset values
    localparam logic [DATA_W-1:0] DIR_RST = 8'hff;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [DATA_W-1:0] CONV_RST = 8'h00;
    // converter control fields
    localparam int CFG_W = 4;
    localparam int CFG_LSB = 0;
    localparam int FMT_BIT = 5;
    localparam int CLK_LSB = 6;
    localparam logic [DATA_W-1:0] CONV_RW_MASK = 8'hef;
    localparam logic [CFG_W-1:0] CFG_DIGITAL_MIN = 4'he;
    // converter channel map
    localparam int NUM_CH = 16;
    localparam int F_CH_BASE = 4;
    localparam int G_CH_TOP = 3;
    localparam int H_CH_BASE = 12;
    localparam int H_AN_LSB = 4;
    // port g peripheral bit positions
    localparam int G_CAP_BIT = 4;
    localparam int G_PWM_BIT = 5;
    localparam int G_DAT_BIT = 6;
    localparam int G_CLK_BIT = 7;
    // pin drive of one port
    typedef struct packed {
        logic [DATA_W-1:0] out;
        logic [DATA_W-1:0] oe;
    } asg_pin_drive_type;
endpackage : asg_pkg

//--- hw/asg_port_slice.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// one port: direction, latch, pin drive and input path
// ****************************************************************
module asg_port_slice
    import asg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, low
    input wire logic dir_wr, // direction write strobe
    input wire logic data_wr, // latch write strobe
    input wire logic [WIDTH-1:0] wdata, // write data
    input wire logic [WIDTH-1:0] analog, // pins held analog
    input wire logic [WIDTH-1:0] per_en, // peripheral owns pin
    input wire logic [WIDTH-1:0] per_out, // peripheral level
    input wire logic [WIDTH-1:0] per_oe, // peripheral enable
    input wire logic [WIDTH-1:0] pin_i, // raw pin levels
    output logic [WIDTH-1:0] dir_q, // direction register
    output logic [WIDTH-1:0] latch_q, // output latch
    output asg_pin_drive_type drive_q, // pin drive
    output logic [WIDTH-1:0] level_q // synced, masked level
);
    // refuse widths the drive struct cannot carry
    if (WIDTH != DATA_W) begin : g_bad_width
        $error("asg_port_slice: WIDTH must equal DATA_W");
    end

    logic [WIDTH-1:0] dir_d; // next direction
    logic [WIDTH-1:0] latch_d; // next latch
    logic [WIDTH-1:0] sync1_q; // first sync stage
    logic [WIDTH-1:0] sync2_q; // second sync stage
    logic [WIDTH-1:0] level_d; // next visible level
    asg_pin_drive_type drive_d; // next drive

    // ************************************************************
    // registers written by software
    // ************************************************************
    always_comb begin
        dir_d = dir_q;
        latch_d = latch_q;
        if (dir_wr) begin
            dir_d = wdata;
        end
        // a write lands in the latch only; pins follow it where the latch drives them
        if (data_wr) begin
            latch_d = wdata;
        end
    end

    // ************************************************************
    // per-bit pin driver and input gating
    // ************************************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            if (per_en[i]) begin
                // peripheral takes the pin over the latch
                drive_d.out[i] = per_out[i];
                drive_d.oe[i] = per_oe[i];
            end else begin
                drive_d.out[i] = latch_q[i];
                // one in direction, or analog, leaves pin undriven
                drive_d.oe[i] = ~dir_q[i] & ~analog[i];
            end
            // analog pins block the digital input path
            level_d[i] = sync2_q[i] & ~analog[i];
        end
    end

    // ************************************************************
    // state registers and pin synchroniser
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dir_q <= DIR_RST;
            latch_q <= DATA_RST;
            sync1_q <= '0;
            sync2_q <= '0;
            level_q <= '0;
            drive_q <= '0;
        end else begin
            dir_q <= dir_d;
            latch_q <= latch_d;
            // pins are asynchronous: two stages before any use
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            level_q <= level_d;
            drive_q <= drive_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_analog_blocks_input;
        @(posedge clk_sys) disable iff (!nrst)
        (analog == $past(analog)) |-> ((level_q & analog) == '0);
    endproperty
    a_analog_blocks_input: assert property (p_analog_blocks_input)
        else $error("analog pin shows a digital level");
endmodule : asg_port_slice
`default_nettype wire
